// ---- src/cocr_pkg.sv ----
// Purpose: shared constants for the clock output control register bank
// Assumes: byte-wide registers reached over the two-wire serial port
// Notes: field positions are bit indices inside each register byte
`default_nettype none
package cocr_pkg;
  // serial addresses, read/write bit included
  localparam logic [7:0] CO_WR_ADDR = 8'hD2;
  localparam logic [7:0] CO_RD_ADDR = 8'hD3;
  localparam logic [3:0] CO_BITS_PER_BYTE = 4'h8;
  // command code and byte count precede register data on writes
  localparam logic [7:0] CO_HDR_BYTES = 8'h02;
  localparam logic [7:0] CO_RD_BYTE_COUNT = 8'h06;
  // register offsets
  localparam logic [2:0] CO_CPU_PAIR_CONTROL = 3'h1;
  localparam logic [2:0] CO_PCI_OUTPUT_CONTROL = 3'h2;
  localparam logic [2:0] CO_FREE_PCI_AND_48M_CONTROL = 3'h3;
  localparam logic [2:0] CO_SIXTY_SIX_OUTPUT_CONTROL = 3'h4;
  localparam logic [2:0] CO_SPREAD_DELAY_EDGE_CONTROL = 3'h5;
  // reset values
  localparam logic [7:0] CO_CPU_PAIR_RST = 8'h07;
  localparam logic [7:0] CO_PCI_OUT_RST = 8'h7F;
  localparam logic [7:0] CO_FREE_PCI_RST = 8'hC7;
  localparam logic [7:0] CO_SIXTY_SIX_RST = 8'h3F;
  localparam logic [7:0] CO_SPREAD_RST = 8'h40;
  // field positions
  localparam int CO_MULT_BIT = 7;
  localparam int CO_CPU_FLOAT_BIT = 6;
  localparam int CO_CPU_FREE_LSB = 3;
  localparam int CO_CPU_EN_LSB = 0;
  localparam int CO_REF_LOW_BIT = 7;
  localparam int CO_PCI_EN_LSB = 0;
  localparam int CO_DOT_EN_BIT = 7;
  localparam int CO_USB_EN_BIT = 6;
  localparam int CO_FPCI_STOPQ_LSB = 3;
  localparam int CO_FPCI_EN_LSB = 0;
  localparam int CO_SS_HI_BIT = 7;
  localparam int CO_FIXED66_EN_MSB = 5;
  localparam int CO_BUF66_EN_LSB = 0;
  localparam int CO_SS_MID_BIT = 7;
  localparam int CO_SS_LO_BIT = 6;
  localparam int CO_DELAY_LSB = 4;
  localparam int CO_DOT_SLOW_BIT = 2;
  localparam int CO_USB_SLOW_BIT = 0;
  localparam int CO_CPU_PAIRS = 3;
  localparam int CO_PCI_OUTS = 7;
  localparam int CO_FPCI_OUTS = 3;

  typedef enum logic [2:0] {
    CO_SMB_IDLE = 3'b000,
    CO_SMB_ADDR = 3'b001,
    CO_SMB_ACK = 3'b010,
    CO_SMB_WR = 3'b011,
    CO_SMB_TX = 3'b100,
    CO_SMB_MACK = 3'b101
  } cocr_smb_state_e;
endpackage
`default_nettype wire

// ---- src/cocr_smb_if.sv ----
// Purpose: byte-level link between serial engine and register bank
// Assumes: single clock domain
// Notes: strobes are one-cycle pulses
`default_nettype none
interface cocr_smb_if;
  logic frame_start;
  logic frame_stop;
  logic wr_valid;
  logic [7:0] wr_byte;
  logic rd_next;
  logic [7:0] rd_byte;
  logic sda_drive_n;
  modport slave(output frame_start, frame_stop, wr_valid, wr_byte, rd_next, sda_drive_n, input rd_byte);
  modport bank(input frame_start, frame_stop, wr_valid, wr_byte, rd_next, sda_drive_n, output rd_byte);
endinterface
`default_nettype wire

// ---- src/cocr_smbus_slave.sv ----
// Purpose: two-wire serial slave, bit and byte handling
// Assumes: serial pins synchronous to i_clk_sys, clock much faster than serial clock
// Notes: open-drain data is pulled low only through sda_drive_n
`default_nettype none
module cocr_smbus_slave
  import cocr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_sdata,
  cocr_smb_if.slave bus
);
  logic scl_q;
  logic sda_q;
  logic read_mode;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  cocr_smb_state_e state;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_sclk;
      sda_q <= i_sdata;
    end
  end

  assign scl_rise = i_sclk & ~scl_q;
  assign scl_fall = ~i_sclk & scl_q;
  assign start_det = scl_q & i_sclk & sda_q & ~i_sdata;
  assign stop_det = scl_q & i_sclk & ~sda_q & i_sdata;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state <= CO_SMB_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      read_mode <= 1'b0;
      bus.sda_drive_n <= 1'b1;
      bus.frame_start <= 1'b0;
      bus.frame_stop <= 1'b0;
      bus.wr_valid <= 1'b0;
      bus.wr_byte <= 8'h00;
      bus.rd_next <= 1'b0;
    end else begin
      bus.frame_start <= 1'b0;
      bus.frame_stop <= 1'b0;
      bus.wr_valid <= 1'b0;
      bus.rd_next <= 1'b0;
      if (start_det) begin
        state <= CO_SMB_ADDR;
        bit_cnt <= 4'h0;
        bus.sda_drive_n <= 1'b1;
        bus.frame_start <= 1'b1;
      end else if (stop_det) begin
        state <= CO_SMB_IDLE;
        bus.sda_drive_n <= 1'b1;
        bus.frame_stop <= 1'b1;
      end else begin
        case (state)
          CO_SMB_ADDR, CO_SMB_WR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], i_sdata};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == CO_BITS_PER_BYTE) begin
              bit_cnt <= 4'h0;
              if (state == CO_SMB_WR) begin
                bus.wr_valid <= 1'b1;
                bus.wr_byte <= shreg;
                bus.sda_drive_n <= 1'b0;
                state <= CO_SMB_ACK;
              end else if (shreg == CO_WR_ADDR || shreg == CO_RD_ADDR) begin
                read_mode <= shreg[0];
                bus.sda_drive_n <= 1'b0;
                state <= CO_SMB_ACK;
              end else begin
                state <= CO_SMB_IDLE;
              end
            end
          end
          CO_SMB_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (read_mode) begin
                shreg <= {bus.rd_byte[6:0], 1'b0};
                bus.sda_drive_n <= bus.rd_byte[7];
                bus.rd_next <= 1'b1;
                state <= CO_SMB_TX;
              end else begin
                bus.sda_drive_n <= 1'b1;
                state <= CO_SMB_WR;
              end
            end
          end
          CO_SMB_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == CO_BITS_PER_BYTE) begin
                bus.sda_drive_n <= 1'b1;
                state <= CO_SMB_MACK;
              end else begin
                bus.sda_drive_n <= shreg[7];
                shreg <= {shreg[6:0], 1'b0};
              end
            end
          end
          CO_SMB_MACK: begin
            if (scl_rise) begin
              state <= i_sdata ? CO_SMB_IDLE : CO_SMB_ACK;
            end
          end
          CO_SMB_IDLE: begin
            bus.sda_drive_n <= 1'b1;
          end
          default: begin
            state <= CO_SMB_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- src/cocr_regs.sv ----
// Purpose: serial control bytes 1 to 5 and the output gating they steer
// Assumes: raw clock levels arrive synchronous to i_clk_sys; byte 0 bit 6 is an input
// Notes: every gated output follows its raw clock one cycle late
`default_nettype none
module cocr_regs
  import cocr_pkg::*;
#(
  parameter logic [7:0] RD_BYTE_COUNT = CO_RD_BYTE_COUNT
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_sdata,
  output logic o_sdata,
  output logic o_sdata_oe_n,
  input wire logic i_current_multiplier_select,
  input wire logic i_cpu_clock_stop_n,
  input wire logic i_power_down_n,
  input wire logic i_pci_clock_stop_n,
  input wire logic i_pd_float_mode,
  input wire logic i_cpu_clk_raw,
  input wire logic i_pci_clk_raw,
  input wire logic i_clk_48m_raw,
  input wire logic i_clk_66m_raw,
  output logic [2:0] o_cpu_true_out,
  output logic [2:0] o_cpu_complement_out,
  output logic [2:0] o_cpu_float,
  output logic [6:0] o_pci_out,
  output logic [2:0] o_free_pci_clock,
  output logic o_dot_clock_48m,
  output logic o_usb_clock_48m,
  output logic [2:0] o_fixed_66m_clock,
  output logic [2:0] o_buffered_66_out,
  output logic o_ref_low_strength,
  output logic [2:0] o_spread_select,
  output logic [1:0] o_external_66_delay,
  output logic o_dot_slow_edge,
  output logic o_usb_slow_edge
);
  if (RD_BYTE_COUNT == 8'h00) begin : g_chk
    $error("RD_BYTE_COUNT must be non-zero");
  end

  cocr_smb_if smb ();

  cocr_smbus_slave u_slave (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_sclk(i_sclk),
    .i_sdata(i_sdata),
    .bus(smb.slave)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register store
  logic [7:0] regs [1:5];
  logic [7:0] byte_idx;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;

  // maps a data byte number to a register offset, zero when unmapped
  function automatic logic [2:0] reg_sel(input logic [7:0] num);
    if (num >= 8'(CO_CPU_PAIR_CONTROL) && num <= 8'(CO_SPREAD_DELAY_EDGE_CONTROL)) begin
      return num[2:0];
    end
    return 3'h0;
  endfunction

  function automatic logic [7:0] reset_value(input logic [2:0] sel);
    case (sel)
      CO_CPU_PAIR_CONTROL: return CO_CPU_PAIR_RST;
      CO_PCI_OUTPUT_CONTROL: return CO_PCI_OUT_RST;
      CO_FREE_PCI_AND_48M_CONTROL: return CO_FREE_PCI_RST;
      CO_SIXTY_SIX_OUTPUT_CONTROL: return CO_SIXTY_SIX_RST;
      CO_SPREAD_DELAY_EDGE_CONTROL: return CO_SPREAD_RST;
      default: return 8'h00;
    endcase
  endfunction

  // gate follows its wish only while the raw clock is low
  function automatic logic gate_next(input logic cur, input logic want, input logic raw);
    return raw ? cur : want;
  endfunction

  // write data byte n lands in register n once the two header bytes pass
  assign wr_sel = (byte_idx >= CO_HDR_BYTES) ? reg_sel(byte_idx - CO_HDR_BYTES) : 3'h0;
  // reads return the byte count first, then byte 0 onward
  assign rd_sel = (byte_idx != 8'h00) ? reg_sel(byte_idx - 8'h01) : 3'h0;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || smb.frame_start) begin
      byte_idx <= 8'h00;
    end else if ((smb.wr_valid || smb.rd_next) && byte_idx != 8'hFF) begin
      byte_idx <= byte_idx + 8'h01;
    end
  end

  // contents change only by reset or a write at the write address
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      for (int k = 1; k <= 5; k++) begin
        regs[k] <= reset_value(3'(k));
      end
    end else if (smb.wr_valid && wr_sel != 3'h0) begin
      regs[wr_sel] <= smb.wr_byte;
      if (wr_sel == CO_CPU_PAIR_CONTROL) begin
        regs[wr_sel][CO_MULT_BIT] <= 1'b0;
      end
    end
  end

  always_comb begin
    if (byte_idx == 8'h00) begin
      smb.rd_byte = RD_BYTE_COUNT;
    end else if (rd_sel == CO_CPU_PAIR_CONTROL) begin
      smb.rd_byte = {i_current_multiplier_select, regs[CO_CPU_PAIR_CONTROL][6:0]};
    end else if (rd_sel != 3'h0) begin
      smb.rd_byte = regs[rd_sel];
    end else begin
      smb.rd_byte = 8'h00;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_sdata <= 1'b0;
      o_sdata_oe_n <= 1'b1;
    end else begin
      o_sdata <= 1'b0;
      o_sdata_oe_n <= smb.sda_drive_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // desired run state of every gated output
  logic [7:0] cpu_r;
  logic [7:0] pci_r;
  logic [7:0] fp_r;
  logic [7:0] s66_r;
  logic [7:0] ss_r;
  logic [2:0] cpu_want;
  logic cpu_float_want;
  logic [6:0] pci_want;
  logic [2:0] fpci_want;
  logic [2:0] fixed_want;

  assign cpu_r = regs[CO_CPU_PAIR_CONTROL];
  assign pci_r = regs[CO_PCI_OUTPUT_CONTROL];
  assign fp_r = regs[CO_FREE_PCI_AND_48M_CONTROL];
  assign s66_r = regs[CO_SIXTY_SIX_OUTPUT_CONTROL];
  assign ss_r = regs[CO_SPREAD_DELAY_EDGE_CONTROL];

  always_comb begin
    for (int i = 0; i < CO_CPU_PAIRS; i++) begin
      cpu_want[i] = cpu_r[CO_CPU_EN_LSB + i]
        && (i_cpu_clock_stop_n || cpu_r[CO_CPU_FREE_LSB + i])
        && i_power_down_n;
    end
    for (int i = 0; i < CO_PCI_OUTS; i++) begin
      pci_want[i] = pci_r[CO_PCI_EN_LSB + i] && i_pci_clock_stop_n;
    end
    for (int i = 0; i < CO_FPCI_OUTS; i++) begin
      fpci_want[i] = fp_r[CO_FPCI_EN_LSB + i]
        && !(fp_r[CO_FPCI_STOPQ_LSB + i] && !i_pci_clock_stop_n);
    end
    for (int i = 0; i < 3; i++) begin
      fixed_want[i] = s66_r[CO_FIXED66_EN_MSB - i];
    end
  end

  // float on stop needs bit 6; at power down either bit 6 or byte 0 bit 6 alone is enough
  assign cpu_float_want = (!i_cpu_clock_stop_n && cpu_r[CO_CPU_FLOAT_BIT])
    || (!i_power_down_n && (cpu_r[CO_CPU_FLOAT_BIT] || i_pd_float_mode));

  ////////////////////////////////////////////////////////////////////////////
  // gates move only in the low phase, so only a cpu pair pulse can be clipped, when the raw low phase spans more than one cycle
  logic [2:0] cpu_gate;
  logic cpu_float_gate;
  logic [6:0] pci_gate;
  logic [2:0] fpci_gate;
  logic dot_gate;
  logic usb_gate;
  logic [2:0] fixed_gate;
  logic [2:0] buf_gate;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cpu_gate <= 3'h0;
      cpu_float_gate <= 1'b0;
    end else begin
      for (int i = 0; i < CO_CPU_PAIRS; i++) begin
        cpu_gate[i] <= gate_next(cpu_gate[i], cpu_want[i], i_cpu_clk_raw);
      end
      cpu_float_gate <= gate_next(cpu_float_gate, cpu_float_want, i_cpu_clk_raw);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pci_gate <= 7'h00;
      fpci_gate <= 3'h0;
    end else begin
      for (int i = 0; i < CO_PCI_OUTS; i++) begin
        pci_gate[i] <= gate_next(pci_gate[i], pci_want[i], i_pci_clk_raw);
      end
      for (int i = 0; i < CO_FPCI_OUTS; i++) begin
        fpci_gate[i] <= gate_next(fpci_gate[i], fpci_want[i], i_pci_clk_raw);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      dot_gate <= 1'b0;
      usb_gate <= 1'b0;
      fixed_gate <= 3'h0;
      buf_gate <= 3'h0;
    end else begin
      dot_gate <= gate_next(dot_gate, fp_r[CO_DOT_EN_BIT], i_clk_48m_raw);
      usb_gate <= gate_next(usb_gate, fp_r[CO_USB_EN_BIT], i_clk_48m_raw);
      for (int i = 0; i < 3; i++) begin
        fixed_gate[i] <= gate_next(fixed_gate[i], fixed_want[i], i_clk_66m_raw);
        buf_gate[i] <= gate_next(buf_gate[i], s66_r[CO_BUF66_EN_LSB + i], i_clk_66m_raw);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gated clock outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_cpu_true_out <= 3'h7;
      o_cpu_complement_out <= 3'h0;
      o_cpu_float <= 3'h0;
    end else begin
      for (int i = 0; i < CO_CPU_PAIRS; i++) begin
        o_cpu_true_out[i] <= cpu_gate[i] ? i_cpu_clk_raw : 1'b1;
        o_cpu_complement_out[i] <= cpu_gate[i] ? ~i_cpu_clk_raw : 1'b0;
      end
      o_cpu_float <= {3{cpu_float_gate}};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_pci_out <= 7'h00;
      o_free_pci_clock <= 3'h0;
    end else begin
      o_pci_out <= pci_gate & {7{i_pci_clk_raw}};
      o_free_pci_clock <= fpci_gate & {3{i_pci_clk_raw}};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_dot_clock_48m <= 1'b0;
      o_usb_clock_48m <= 1'b0;
      o_fixed_66m_clock <= 3'h0;
      o_buffered_66_out <= 3'h0;
    end else begin
      o_dot_clock_48m <= dot_gate & i_clk_48m_raw;
      o_usb_clock_48m <= usb_gate & i_clk_48m_raw;
      o_fixed_66m_clock <= fixed_gate & {3{i_clk_66m_raw}};
      o_buffered_66_out <= buf_gate & {3{i_clk_66m_raw}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // static settings
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_ref_low_strength <= CO_PCI_OUT_RST[CO_REF_LOW_BIT];
      o_spread_select <= {CO_SIXTY_SIX_RST[CO_SS_HI_BIT], CO_SPREAD_RST[CO_SS_MID_BIT],
                          CO_SPREAD_RST[CO_SS_LO_BIT]};
      o_external_66_delay <= CO_SPREAD_RST[CO_DELAY_LSB +: 2];
      o_dot_slow_edge <= CO_SPREAD_RST[CO_DOT_SLOW_BIT];
      o_usb_slow_edge <= CO_SPREAD_RST[CO_USB_SLOW_BIT];
    end else begin
      o_ref_low_strength <= pci_r[CO_REF_LOW_BIT];
      o_spread_select <= {s66_r[CO_SS_HI_BIT], ss_r[CO_SS_MID_BIT], ss_r[CO_SS_LO_BIT]};
      o_external_66_delay <= ss_r[CO_DELAY_LSB +: 2];
      o_dot_slow_edge <= ss_r[CO_DOT_SLOW_BIT];
      o_usb_slow_edge <= ss_r[CO_USB_SLOW_BIT];
    end
  end
endmodule
`default_nettype wire

// ---- bench/cocr_regs_chk.sv ----
// Purpose: port-level checks for the clock output control bank
// Assumes: serial pins and raw clocks are sampled on i_clk_sys
// Notes: attached to the bank by bind at the foot
`default_nettype none
module cocr_regs_chk (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_power_down_n,
  input wire logic i_pd_float_mode,
  input wire logic i_cpu_clock_stop_n,
  input wire logic i_pci_clock_stop_n,
  input wire logic i_cpu_clk_raw,
  input wire logic i_pci_clk_raw,
  input wire logic i_clk_48m_raw,
  input wire logic o_sdata,
  input wire logic o_sdata_oe_n,
  input wire logic [2:0] o_cpu_true_out,
  input wire logic [2:0] o_cpu_complement_out,
  input wire logic [2:0] o_cpu_float,
  input wire logic [6:0] o_pci_out,
  input wire logic [2:0] o_free_pci_clock,
  input wire logic o_dot_clock_48m
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////////////////
  sequence pci_stop_held;
    !i_pci_clock_stop_n && !i_pci_clk_raw ##1 !i_pci_clock_stop_n;
  endsequence
  sequence pd_held;
    !i_power_down_n && !i_cpu_clk_raw ##1 !i_power_down_n;
  endsequence
  sequence pd_float_held;
    !i_power_down_n && i_pd_float_mode && !i_cpu_clk_raw ##1 !i_power_down_n && i_pd_float_mode;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  pci_stop_low_a: assert property (pci_stop_held |=> o_pci_out == 7'h00)
    else $error("pci outputs not low during stop");
  pd_float_a: assert property (pd_float_held |=> o_cpu_float == 3'h7)
    else $error("cpu outputs not floated at power down");
  pd_disable_a: assert property (pd_held |=> o_cpu_float == 3'h7 ||
    (o_cpu_true_out == 3'h7 && o_cpu_complement_out == 3'h0)) else $error("cpu pairs not parked at power down");
  pair_levels_a: assert property (o_cpu_float == 3'h0 |-> (o_cpu_true_out & o_cpu_complement_out) == 3'h0)
    else $error("cpu true and complement both high");
  float_release_a: assert property (i_cpu_clock_stop_n && i_power_down_n && !i_cpu_clk_raw |=> ##1
    o_cpu_float == 3'h0) else $error("cpu pairs float with both stop pins high");
  ack_low_phase_a: assert property ($changed(o_sdata_oe_n) |-> !i_sclk && !$past(i_sclk) && !$past(i_sclk, 2))
    else $error("data line changed outside clock low");
  oe_steady_high_a: assert property (i_sclk && $past(i_sclk) |-> $stable(o_sdata_oe_n) && o_sdata == 1'b0)
    else $error("data line moved while clock high");
  pci_rise_raw_a: assert property ($rose(o_pci_out[0]) |-> $past(i_pci_clk_raw) && !$past(i_pci_clk_raw, 2))
    else $error("pci output rose without raw clock");
  fpci_fall_raw_a: assert property ($fell(o_free_pci_clock[0]) |-> !$past(i_pci_clk_raw))
    else $error("free pci output cut short");
  dot_rise_raw_a: assert property ($rose(o_dot_clock_48m) |-> $past(i_clk_48m_raw) && !$past(i_clk_48m_raw, 2))
    else $error("dot clock rose without raw clock");
endmodule
bind cocr_regs cocr_regs_chk i_cocr_regs_chk (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_sclk(i_sclk), .i_power_down_n(i_power_down_n),
  .i_pd_float_mode(i_pd_float_mode), .i_cpu_clock_stop_n(i_cpu_clock_stop_n),
  .i_pci_clock_stop_n(i_pci_clock_stop_n), .i_cpu_clk_raw(i_cpu_clk_raw),
  .i_pci_clk_raw(i_pci_clk_raw), .i_clk_48m_raw(i_clk_48m_raw), .o_sdata(o_sdata), .o_sdata_oe_n(o_sdata_oe_n),
  .o_cpu_true_out(o_cpu_true_out), .o_cpu_complement_out(o_cpu_complement_out), .o_cpu_float(o_cpu_float),
  .o_pci_out(o_pci_out), .o_free_pci_clock(o_free_pci_clock), .o_dot_clock_48m(o_dot_clock_48m)
);
`default_nettype wire

// ---- bench/cocr_host_model.sv ----
// Purpose: serial bus host that programs and reads the bank
// Assumes: data line pulled up; host releases it to send a one
// Notes: every change lands on a falling edge of i_clk
`default_nettype none
module cocr_host_model
  import cocr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_sclk,
  output logic o_sda_rel
);
  timeunit 1ns;
  timeprecision 1ps;
  int half = 4;
  initial begin
    o_sclk = 1'b1;
    o_sda_rel = 1'b1;
  end
  task automatic phase();
    repeat (half) @(negedge i_clk);
  endtask
  task automatic start_cond();
    o_sda_rel = 1'b1;
    phase();
    o_sda_rel = 1'b0;
    phase();
    o_sclk = 1'b0;
  endtask
  task automatic stop_cond();
    o_sda_rel = 1'b0;
    phase();
    o_sclk = 1'b1;
    phase();
    o_sda_rel = 1'b1;
    phase();
  endtask
  // data set while clock low, sampled at end of high phase
  task automatic clock_bit(input logic b, output logic s);
    o_sda_rel = b;
    phase();
    o_sclk = 1'b1;
    phase();
    s = i_sda;
    o_sclk = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s);
    end
    clock_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      b[i] = s;
    end
    clock_bit(nack, s);
  endtask
  task automatic write_regs(input logic [7:0] adr, input logic [47:0] d, output logic ok);
    logic a;
    start_cond();
    send_byte(adr, ok);
    if (ok) begin
      send_byte(8'h00, a);
      ok = ok & a;
      send_byte(8'h06, a);
      ok = ok & a;
      for (int i = 0; i < 6; i++) begin
        send_byte(d[8*i +: 8], a);
        ok = ok & a;
      end
    end
    stop_cond();
  endtask
  task automatic read_regs(output logic [55:0] r, output logic ok);
    logic [7:0] b;
    start_cond();
    send_byte(CO_RD_ADDR, ok);
    for (int i = 0; i < 7; i++) begin
      recv_byte(i == 6, b);
      r[8*i +: 8] = b;
    end
    stop_cond();
  endtask
endmodule
`default_nettype wire

// ---- bench/cocr_regs_test.sv ----
// Purpose: self-checking bench for the clock output control bank
// Assumes: raw clocks come from a free counter; host model drives the bus
// Notes: inputs change on the falling clock edge
`default_nettype none
module cocr_regs_test;
  import cocr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RD_CNT = 8'h03;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic mult = 1'b1;
  logic cpu_stop_n = 1'b1;
  logic pd_n = 1'b1;
  logic pci_stop_n = 1'b1;
  logic pd_float = 1'b0;
  logic [3:0] raw = 4'h0;
  logic sclk, sda_rel, sdata, sdata_out, sdata_oe_n, ref_low, dot, usb, dot_slow, usb_slow;
  logic [2:0] cpu_t, cpu_c, cpu_f, fpci, fix66, buf66, spread;
  logic [6:0] pci;
  logic [1:0] dly;
  int n_mismatch = 0;
  int compares = 0;
  assign sdata = sda_rel && (sdata_oe_n !== 1'b0);
  always #20 i_clk_sys = ~i_clk_sys;
  always @(negedge i_clk_sys) raw <= raw + 4'h1;
  cocr_regs #(.RD_BYTE_COUNT(RD_CNT)) i_cocr_regs (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_sdata(sdata), .o_sdata(sdata_out),
    .o_sdata_oe_n(sdata_oe_n), .i_current_multiplier_select(mult), .i_cpu_clock_stop_n(cpu_stop_n),
    .i_power_down_n(pd_n), .i_pci_clock_stop_n(pci_stop_n), .i_pd_float_mode(pd_float),
    .i_cpu_clk_raw(raw[0]), .i_pci_clk_raw(raw[1]), .i_clk_48m_raw(raw[2]), .i_clk_66m_raw(raw[3]),
    .o_cpu_true_out(cpu_t), .o_cpu_complement_out(cpu_c), .o_cpu_float(cpu_f), .o_pci_out(pci),
    .o_free_pci_clock(fpci), .o_dot_clock_48m(dot), .o_usb_clock_48m(usb), .o_fixed_66m_clock(fix66),
    .o_buffered_66_out(buf66), .o_ref_low_strength(ref_low), .o_spread_select(spread),
    .o_external_66_delay(dly), .o_dot_slow_edge(dot_slow), .o_usb_slow_edge(usb_slow)
  );
  cocr_host_model i_cocr_host_model (.i_clk(i_clk_sys), .i_sda(sdata), .o_sclk(sclk), .o_sda_rel(sda_rel));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [39:0] b15, input logic exp_ok);
    logic ok;
    i_cocr_host_model.write_regs(adr, {b15, 8'hFF}, ok);
    chk("write ack", exp_ok, ok);
  endtask
  task automatic rd(input logic [39:0] exp);
    logic [55:0] r;
    logic ok;
    i_cocr_host_model.read_regs(r, ok);
    chk("read ack", 1'b1, ok);
    chk("byte count", RD_CNT, r[7:0]);
    chk("byte 0", 8'h00, r[15:8]);
    chk("bytes 1 to 5", exp, r[55:16]);
  endtask
  // settle past the slowest raw clock, then gather levels
  task automatic watch(output logic [17:0] ro, output logic [5:0] tc);
    ro = 18'h0;
    tc = 6'h38;
    repeat (10) @(negedge i_clk_sys);
    repeat (16) begin
      @(negedge i_clk_sys);
      ro = ro | {pci, fpci, dot, usb, fix66, buf66};
      tc = {tc[5:3] & cpu_t, tc[2:0] | cpu_c};
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    rd({8'h40, 8'h3F, 8'hC7, 8'h7F, 8'h87});
    chk("static levels", 8'h10, {ref_low, spread, dly, dot_slow, usb_slow});
  endtask
  task automatic t_pattern(input logic m, input logic [39:0] w, input logic [39:0] r, input logic [7:0] st,
                           input logic [17:0] ro_exp, input logic [5:0] tc_exp);
    logic [17:0] ro;
    logic [5:0] tc;
    mult = m;
    wr(CO_WR_ADDR, w, 1'b1);
    rd(r);
    chk("static levels", st, {ref_low, spread, dly, dot_slow, usb_slow});
    watch(ro, tc);
    chk("gated outputs", ro_exp, ro);
    chk("cpu levels", tc_exp, tc);
  endtask
  task automatic t_bad_addr();
    i_cocr_host_model.half = 6;
    wr(8'hA2, 40'h0, 1'b0);
    rd({8'h41, 8'h3F, 8'hC7, 8'h7F, 8'h87});
    i_cocr_host_model.half = 4;
  endtask
  task automatic t_cpu_stop();
    logic [17:0] ro;
    logic [5:0] tc;
    wr(CO_WR_ADDR, {8'h41, 8'h3F, 8'hC7, 8'h7F, 8'h27}, 1'b1);
    cpu_stop_n = 1'b0;
    watch(ro, tc);
    chk("cpu stop levels", 6'h1C, tc);
    chk("cpu float", 3'h0, cpu_f);
    wr(CO_WR_ADDR, {8'h41, 8'h3F, 8'hC7, 8'h7F, 8'h67}, 1'b1);
    watch(ro, tc);
    chk("cpu float", 3'h7, cpu_f);
    cpu_stop_n = 1'b1;
    pd_n = 1'b0;
    watch(ro, tc);
    chk("cpu float", 3'h7, cpu_f);
    wr(CO_WR_ADDR, {8'h41, 8'h3F, 8'hC7, 8'h7F, 8'h27}, 1'b1);
    watch(ro, tc);
    chk("cpu power down", 9'h038, {cpu_f, tc});
    pd_float = 1'b1;
    watch(ro, tc);
    chk("cpu float", 3'h7, cpu_f);
    pd_n = 1'b1;
    pd_float = 1'b0;
  endtask
  task automatic t_pci_stop();
    logic [17:0] ro;
    logic [5:0] tc;
    wr(CO_WR_ADDR, {8'h41, 8'h31, 8'hEF, 8'h0D, 8'h07}, 1'b1);
    pci_stop_n = 1'b0;
    watch(ro, tc);
    chk("pci during stop", 18'h002D9, ro);
    pci_stop_n = 1'b1;
    watch(ro, tc);
    chk("pci after stop", 18'h06FD9, ro);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    @(negedge i_clk_sys);
    t_reset_values();
    t_pattern(1'b0, {8'hA4, 8'h80, 8'h38, 8'h80, 8'hB8}, {8'hA4, 8'h80, 8'h38, 8'h80, 8'h38}, 8'hEA, 18'h0, 6'h38);
    t_pattern(1'b1, {8'h41, 8'h3F, 8'hC7, 8'h7F, 8'h07}, {8'h41, 8'h3F, 8'hC7, 8'h7F, 8'h87}, 8'h11, 18'h3FFFF,
              6'h07);
    t_bad_addr();
    t_cpu_stop();
    t_pci_stop();
    final_report();
  end
  initial begin
    repeat (100000) @(posedge i_clk_sys);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
